//--- shared/msro_pkg.sv
package msro_pkg;

    // Clock rate and clock period in nanoseconds.
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_NS = 8;

    // Rate limits and the rate after default settings, in samples per second.
    localparam logic [7:0] RATE_MIN     = 8'h0A;
    localparam logic [7:0] RATE_MAX     = 8'h9A;
    localparam logic [7:0] RATE_DEFAULT = 8'h14;
    localparam logic [7:0] RATE_ASCII_SLOW_MAX = 8'h1E;
    localparam logic [7:0] RATE_LF_ADVISE      = 8'h3C;

    // Byte times on the serial link, in microseconds, and cycles per byte.
    localparam int BYTE_US_SLOW = 1000;
    localparam int BYTE_US_FAST = 500;
    localparam int BYTE_CYC_SLOW = BYTE_US_SLOW * (CLK_HZ / 1_000_000);
    localparam int BYTE_CYC_FAST = BYTE_US_FAST * (CLK_HZ / 1_000_000);

    // Frame lengths and the terminating carriage return.
    localparam int BIN_BYTES   = 7;
    localparam int ASCII_BYTES = 28;
    localparam logic [7:0] CHAR_CR    = 8'h0D;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_COMMA = 8'h2C;
    localparam logic [7:0] CHAR_MINUS = 8'h2D;
    localparam logic [7:0] CHAR_PLUS  = 8'h2B;
    localparam logic [7:0] CHAR_ZERO  = 8'h30;

    // Poll, filter and send sequencer states.
    typedef enum logic [1:0] {
        MSRO_IDLE = 2'b00,
        MSRO_POLL = 2'b01,
        MSRO_FILT = 2'b10,
        MSRO_SEND = 2'b11
    } msro_state_type;

    // Command gap in microseconds, per rate.
    function automatic int cmd_gap_us(input logic [7:0] rate);
        if (rate <= 8'h14) begin
            return 20000;
        end else if (rate <= 8'h19) begin
            return 16000;
        end else if (rate <= 8'h1E) begin
            return 14000;
        end else if (rate <= 8'h28) begin
            return 10000;
        end else if (rate <= 8'h32) begin
            return 8000;
        end else if (rate <= 8'h3C) begin
            return 7000;
        end else if (rate <= 8'h64) begin
            return 4000;
        end else if (rate <= 8'h7B) begin
            return 3500;
        end
        return 3000;
    endfunction

endpackage

//--- shared/msro_stream_if.sv
`timescale 1ns/1ps
// Byte stream between the framer and the output buffer.
interface msro_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

//--- core/msro_skid.sv
`timescale 1ns/1ps
// Two-entry buffer so a stalled receiver loses no byte.
module msro_skid
    import msro_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic       clock,
    input  wire logic       rst,
    msro_stream_if.dst      up,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [2];
    logic             wp_r;
    logic             rp_r;
    logic [1:0]       cnt_r;
    wire              push = up.valid && up.ready;
    wire              pop  = out_valid && out_ready;

    // Honest full and empty come straight from the count.
    assign up.ready  = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data  = mem_r[rp_r];

    // Pointer and count update; storage is written only on push.
    always_ff @(posedge clock) begin
        if (rst) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= up.data;
                wp_r        <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- core/msro_core.sv
`timescale 1ns/1ps
module msro_core
    import msro_pkg::*;
#(
    parameter int CLOCK_HZ = CLK_HZ,
    parameter int SLOW_CYC = BYTE_CYC_SLOW,
    parameter int FAST_CYC = BYTE_CYC_FAST,
    parameter int CMD_SCALE = CLK_HZ / 1_000_000,
    parameter int COMB_LEN = 4
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        rate_cmd_valid,
    input  wire logic [7:0]  rate_cmd_value,
    output logic             rate_cmd_reject,
    input  wire logic        fmt_ascii,
    input  wire logic        baud_fast,
    input  wire logic        defaults_cmd,
    input  wire logic        restore_cmd,
    input  wire logic [7:0]  nv_rate,
    output logic             nv_store,
    output logic [7:0]       nv_store_rate,
    input  wire logic        cmd_byte_valid,
    input  wire logic [7:0]  cmd_byte,
    output logic             cmd_byte_accept,
    output logic [7:0]       cmd_byte_data,
    input  wire logic        store_cmd,
    input  wire logic        zero_on,
    input  wire logic        zero_off,
    output logic [1:0]       adc_sel,
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic [7:0]       rate_now
);
    localparam int CW = 32;

    msro_stream_if stream ();

    // Legal rate window, shared by host commands and restored settings.
    function automatic logic rate_in_range(input logic [7:0] r);
        return r >= RATE_MIN && r <= RATE_MAX;
    endfunction

    // Sequencer, filter and framing state.
    msro_state_type   state_r;
    logic [7:0]       rate_r;
    logic [CW-1:0]    tick_r;
    logic [CW-1:0]    gap_r;
    logic [CW-1:0]    bytet_r;
    logic [1:0]       axis_r;
    logic signed [15:0] raw_r  [3];
    logic signed [15:0] offs_r [3];
    logic signed [17:0] hist_r [3][COMB_LEN];
    logic signed [17:0] lp_r   [3];
    logic [15:0]      out_r  [3];
    logic [4:0]       idx_r;
    logic             pend_r;
    logic             zero_arm_r;

    // Derived timing and decode. The period is divided out every cycle so that a
    // rate change takes effect at once and no stale period is ever used.
    wire [CW-1:0] period_cyc = CW'(CLOCK_HZ) / CW'(rate_r);
    wire [CW-1:0] gap_cyc    = CW'(cmd_gap_us(rate_r)) * CW'(CMD_SCALE);
    wire [CW-1:0] byte_cyc   = baud_fast ? CW'(FAST_CYC) : CW'(SLOW_CYC);
    wire          rate_ok    = rate_in_range(rate_cmd_value);
    wire          nv_ok      = rate_in_range(nv_rate);
    wire [4:0]    frame_len  = fmt_ascii ? 5'(ASCII_BYTES) : 5'(BIN_BYTES);
    wire          sample_due = tick_r >= period_cyc - 1;
    wire          byte_ok    = bytet_r == '0;

    // Decimal digit of a magnitude for a given power of ten.
    function automatic logic [7:0] dec_char(input logic [15:0] mag, input int p);
        logic [15:0] q;
        q = 16'(mag / 16'(p));
        return CHAR_ZERO + 8'(q % 16'd10);
    endfunction

    // Character of the ASCII frame at a given index: SN d d , d d d SP SP.
    function automatic logic [7:0] ascii_char(input logic [15:0] v, input logic [3:0] k);
        logic [15:0] mag;
        mag = v[15] ? 16'(-v) : v;
        case (k)
            4'd0:    return v[15] ? CHAR_MINUS : CHAR_SPACE;
            4'd1:    return dec_char(mag, 10000);
            4'd2:    return dec_char(mag, 1000);
            4'd3:    return CHAR_COMMA;
            4'd4:    return dec_char(mag, 100);
            4'd5:    return dec_char(mag, 10);
            4'd6:    return dec_char(mag, 1);
            default: return CHAR_SPACE;
        endcase
    endfunction

    // Byte selection for the frame being sent.
    logic [7:0] frame_byte;
    wire  [1:0] bin_axis = 2'(idx_r >> 1);
    wire  [1:0] asc_axis = 2'(idx_r / 5'd9);
    wire  [3:0] asc_pos  = 4'(idx_r % 5'd9);
    always_comb begin
        if (idx_r == frame_len - 5'd1) begin
            frame_byte = CHAR_CR;
        end else if (fmt_ascii) begin
            frame_byte = ascii_char(out_r[asc_axis], asc_pos);
        end else begin
            frame_byte = idx_r[0] ? out_r[bin_axis][7:0] : out_r[bin_axis][15:8];
        end
    end

    assign stream.valid = pend_r && byte_ok;
    assign stream.data  = frame_byte;
    assign rate_now     = rate_r;

    // The converter select follows the axis being polled.
    assign adc_sel      = axis_r;

    // Rate selection: command, defaults and restore from storage.
    // Defaults win over restore, and restore over a host command, in one cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            rate_r          <= RATE_DEFAULT;
            rate_cmd_reject <= 1'b0;
        end else begin
            rate_cmd_reject <= rate_cmd_valid && !rate_ok;
            if (defaults_cmd) begin
                rate_r <= RATE_DEFAULT;
            end else if (restore_cmd && nv_ok) begin
                rate_r <= nv_rate;
            end else if (rate_cmd_valid && rate_ok) begin
                rate_r <= rate_cmd_value;
            end
        end
    end

    // Store request copies the live rate out to nonvolatile storage.
    always_ff @(posedge clock) begin
        if (rst) begin
            nv_store      <= 1'b0;
            nv_store_rate <= 8'h00;
        end else begin
            nv_store      <= store_cmd;
            nv_store_rate <= rate_r;
        end
    end

    // Command bytes arriving before the rate's minimum gap are dropped.
    always_ff @(posedge clock) begin
        if (rst) begin
            gap_r           <= '0;
            cmd_byte_accept <= 1'b0;
            cmd_byte_data   <= 8'h00;
        end else begin
            cmd_byte_accept <= 1'b0;
            if (gap_r != '0) begin
                gap_r <= gap_r - 1;
            end
            if (cmd_byte_valid && gap_r == '0) begin
                cmd_byte_accept <= 1'b1;
                cmd_byte_data   <= cmd_byte;
                gap_r           <= gap_cyc - 1;
            end
        end
    end

    // Sample period tick; a late frame simply holds off the next sample.
    // So an overlong frame lowers the real rate instead of dropping bytes.
    always_ff @(posedge clock) begin
        if (rst) begin
            tick_r <= '0;
        end else if (sample_due && state_r == MSRO_IDLE) begin
            tick_r <= '0;
        end else if (!sample_due) begin
            tick_r <= tick_r + 1;
        end
    end

    // Zero reading: arm captures the next corrected-free reading as offset.
    always_ff @(posedge clock) begin
        if (rst) begin
            zero_arm_r <= 1'b0;
        end else if (zero_on) begin
            zero_arm_r <= 1'b1;
        end else if (state_r == MSRO_FILT) begin
            zero_arm_r <= 1'b0;
        end
    end

    // Poll, filter and send sequence.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r   <= MSRO_IDLE;
            axis_r    <= 2'd0;
            adc_start <= 1'b0;
            idx_r     <= 5'd0;
            pend_r    <= 1'b0;
            for (int a = 0; a < 3; a++) begin
                raw_r[a]  <= 16'sh0000;
                offs_r[a] <= 16'sh0000;
                lp_r[a]   <= 18'sh0_0000;
                out_r[a]  <= 16'h0000;
                for (int t = 0; t < COMB_LEN; t++) begin
                    hist_r[a][t] <= 18'sh0_0000;
                end
            end
        end else begin
            adc_start <= 1'b0;
            if (zero_off) begin
                for (int a = 0; a < 3; a++) begin
                    offs_r[a] <= 16'sh0000;
                end
            end
            case (state_r)
                MSRO_IDLE: begin
                    if (sample_due) begin
                        axis_r    <= 2'd0;
                        adc_start <= 1'b1;
                        state_r   <= MSRO_POLL;
                    end
                end
                MSRO_POLL: begin
                    if (adc_done) begin
                        raw_r[axis_r] <= adc_data - offs_r[axis_r];
                        if (axis_r == 2'd2) begin
                            state_r <= MSRO_FILT;
                        end else begin
                            axis_r    <= axis_r + 2'd1;
                            adc_start <= 1'b1;
                        end
                    end
                end
                MSRO_FILT: begin
                    for (int a = 0; a < 3; a++) begin
                        if (zero_arm_r) begin
                            offs_r[a] <= 16'(raw_r[a] + offs_r[a]);
                        end
                        // Comb: moving sum keeps linear phase; low-pass quarters the step.
                        hist_r[a][0] <= 18'(raw_r[a]);
                        for (int t = 1; t < COMB_LEN; t++) begin
                            hist_r[a][t] <= hist_r[a][t-1];
                        end
                        lp_r[a]  <= lp_r[a] + ((18'(raw_r[a]) - hist_r[a][COMB_LEN-1]) >>> 2);
                        // The output lags one sample, so the first frame reads zero.
                        out_r[a] <= 16'(lp_r[a]);
                    end
                    idx_r   <= 5'd0;
                    pend_r  <= 1'b1;
                    state_r <= MSRO_SEND;
                end
                MSRO_SEND: begin
                    // A full buffer only holds the byte; nothing is skipped.
                    if (stream.valid && stream.ready) begin
                        if (idx_r == frame_len - 5'd1) begin
                            pend_r  <= 1'b0;
                            state_r <= MSRO_IDLE;
                        end else begin
                            idx_r <= idx_r + 5'd1;
                        end
                    end
                end
                default: begin
                    state_r <= MSRO_IDLE;
                end
            endcase
        end
    end

    // Byte pacing at the link's byte time.
    always_ff @(posedge clock) begin
        if (rst) begin
            bytet_r <= '0;
        end else if (stream.valid && stream.ready) begin
            bytet_r <= byte_cyc - 1;
        end else if (bytet_r != '0) begin
            bytet_r <= bytet_r - 1;
        end
    end

    // Output buffer absorbs receiver stalls.
    msro_skid #(
        .WIDTH (8)
    ) u_skid (
        .clock     (clock),
        .rst       (rst),
        .up        (stream),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );
endmodule

//--- verif/msro_core_checker.sv
`timescale 1ns/1ps
// Port-level checker for the rate, command and stream relations of the core.
module msro_core_checker
    import msro_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       rate_cmd_valid,
    input wire logic [7:0] rate_cmd_value,
    input wire logic       rate_cmd_reject,
    input wire logic       defaults_cmd,
    input wire logic       restore_cmd,
    input wire logic [7:0] nv_rate,
    input wire logic       store_cmd,
    input wire logic       nv_store,
    input wire logic       cmd_byte_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic       cmd_byte_accept,
    input wire logic [7:0] cmd_byte_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic [7:0] rate_now
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // Lone commands only, so no priority between command kinds is assumed.
    wire cmd_bad = rate_cmd_valid && (rate_cmd_value < RATE_MIN || rate_cmd_value > RATE_MAX);
    wire lone    = !defaults_cmd && !restore_cmd;
    wire nv_ok   = nv_rate >= RATE_MIN && nv_rate <= RATE_MAX;

    property p_reset_rate;
        $past(rst) |-> rate_now == RATE_DEFAULT && !tx_valid;
    endproperty
    property p_set;
        rate_cmd_valid && !cmd_bad && lone |=> rate_now == $past(rate_cmd_value);
    endproperty
    property p_reject;
        cmd_bad |=> rate_cmd_reject;
    endproperty
    property p_keep;
        cmd_bad && lone |=> $stable(rate_now);
    endproperty
    property p_no_false;
        rate_cmd_reject |-> $past(cmd_bad);
    endproperty
    property p_default;
        defaults_cmd && !rate_cmd_valid && !restore_cmd |=> rate_now == RATE_DEFAULT;
    endproperty
    property p_restore;
        restore_cmd && nv_ok && !rate_cmd_valid && !defaults_cmd |=> rate_now == $past(nv_rate);
    endproperty
    property p_store;
        store_cmd |=> nv_store;
    endproperty
    property p_accept;
        cmd_byte_accept |-> $past(cmd_byte_valid) && cmd_byte_data == $past(cmd_byte);
    endproperty
    property p_gap;
        cmd_byte_accept |=> !cmd_byte_accept [*8];
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty

    a_reset_rate: assert property (p_reset_rate) else $error("bad state after reset");
    a_set: assert property (p_set) else $error("rate not taken");
    a_reject: assert property (p_reject) else $error("bad rate not refused");
    a_keep: assert property (p_keep) else $error("rate changed on refusal");
    a_no_false: assert property (p_no_false) else $error("spurious refusal");
    a_default: assert property (p_default) else $error("default rate wrong");
    a_restore: assert property (p_restore) else $error("restore wrong");
    a_store: assert property (p_store) else $error("store pulse missing");
    a_accept: assert property (p_accept) else $error("accept without byte");
    a_gap: assert property (p_gap) else $error("bytes accepted too close");
    a_hold: assert property (p_hold) else $error("stalled byte changed");

    // Main scenarios reached.
    c_reject: cover property (rate_cmd_reject);
    c_accept: cover property (cmd_byte_accept);
    c_store: cover property (nv_store);
    c_frame: cover property (tx_valid && tx_ready && tx_data == CHAR_CR);
endmodule

//--- verif/msro_adc_model.sv
`timescale 1ns/1ps
// Converter model: each start is answered by one done pulse after a delay.
module msro_adc_model
    import msro_pkg::*;
#(
    parameter int DELAY = 3
) (
    input  wire logic   clock,
    input  wire logic   rst,
    input  wire logic   adc_start,
    input  wire logic   slow,
    output logic        adc_done,
    output logic [15:0] adc_data
);
    int          count_r;
    logic [15:0] sample_r;

    // Data toggles outside done so a sampling slip shows as a wrong value.
    always_ff @(posedge clock) begin
        if (rst) begin
            count_r  <= 0;
            sample_r <= 16'h0123;
            adc_done <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            adc_done <= 1'b0;
            adc_data <= ~adc_data;
            if (adc_start) begin
                count_r <= slow ? DELAY * 8 : DELAY;
            end else if (count_r == 1) begin
                adc_done <= 1'b1;
                adc_data <= sample_r;
                sample_r <= sample_r + 16'h0321;
                count_r  <= 0;
            end else if (count_r > 1) begin
                count_r <= count_r - 1;
            end
        end
    end
endmodule

//--- verif/magnetometer_sample_rate_output_test.sv
`timescale 1ns/1ps
// Directed bench for rate control, settings storage and command spacing.
module magnetometer_sample_rate_output_test
    import msro_pkg::*;
;
    logic clock, rst, rate_cmd_valid, fmt_ascii, baud_fast, defaults_cmd, restore_cmd;
    logic cmd_byte_valid, store_cmd, zero_on, zero_off, tx_ready, adc_slow;
    logic [7:0] rate_cmd_value, nv_rate, cmd_byte;
    wire logic rate_cmd_reject, nv_store, cmd_byte_accept, adc_start, adc_done, tx_valid;
    wire logic [7:0] nv_store_rate, cmd_byte_data, tx_data, rate_now;
    wire logic [15:0] adc_data;
    int failures = 0;
    int n_checks = 0;

    msro_core #(.CLOCK_HZ(10000), .SLOW_CYC(20), .FAST_CYC(20), .CMD_SCALE(1),
        .COMB_LEN(4)) dut (
        .clock(clock), .rst(rst), .rate_cmd_valid(rate_cmd_valid),
        .rate_cmd_value(rate_cmd_value), .rate_cmd_reject(rate_cmd_reject),
        .fmt_ascii(fmt_ascii), .baud_fast(baud_fast), .defaults_cmd(defaults_cmd),
        .restore_cmd(restore_cmd), .nv_rate(nv_rate), .nv_store(nv_store),
        .nv_store_rate(nv_store_rate), .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte),
        .cmd_byte_accept(cmd_byte_accept), .cmd_byte_data(cmd_byte_data),
        .store_cmd(store_cmd), .zero_on(zero_on), .zero_off(zero_off), .adc_sel(),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rate_now(rate_now));

    msro_adc_model adc (.clock(clock), .rst(rst), .adc_start(adc_start), .slow(adc_slow),
        .adc_done(adc_done), .adc_data(adc_data));

    // Free-running 125 MHz clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One-cycle rate command; the answer is looked at in the following cycle.
    task automatic rate_cmd(input logic [7:0] v);
        @(posedge clock);
        rate_cmd_valid <= 1'b1;
        rate_cmd_value <= v;
        @(posedge clock);
        rate_cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic send_byte(input logic [7:0] b, input logic exp);
        @(posedge clock);
        cmd_byte_valid <= 1'b1;
        cmd_byte       <= b;
        @(posedge clock);
        cmd_byte_valid <= 1'b0;
        #1;
        check(cmd_byte_accept, exp, "byte acceptance");
        if (exp) begin
            check(cmd_byte_data, b, "accepted byte");
        end
    endtask

    task automatic test_rates;
        logic [7:0] vals [7] = '{8'h9A, 8'h0A, 8'h09, 8'h9B, 8'h00, 8'hFF, 8'h3C};
        logic [7:0] exp;
        logic       ok;
        exp = RATE_DEFAULT;
        foreach (vals[i]) begin
            ok = vals[i] >= 8'h0A && vals[i] <= 8'h9A;
            exp = ok ? vals[i] : exp;
            rate_cmd(vals[i]);
            check(rate_now, exp, "rate after command");
            check(rate_cmd_reject, !ok, "refusal pulse");
        end
    endtask

    task automatic test_settings;
        rate_cmd(8'h9A);
        @(posedge clock);
        defaults_cmd <= 1'b1;
        @(posedge clock);
        defaults_cmd <= 1'b0;
        #1;
        check(rate_now, 8'h14, "default rate");
        rate_cmd(8'h64);
        @(posedge clock);
        store_cmd <= 1'b1;
        @(posedge clock);
        store_cmd <= 1'b0;
        #1;
        check(nv_store, 1'b1, "store pulse");
        check(nv_store_rate, 8'h64, "stored rate");
        nv_rate <= 8'h0A;
        @(posedge clock);
        restore_cmd <= 1'b1;
        @(posedge clock);
        restore_cmd <= 1'b0;
        nv_rate     <= 8'hFF;
        #1;
        check(rate_now, 8'h0A, "restored rate");
        @(posedge clock);
        restore_cmd <= 1'b1;
        @(posedge clock);
        restore_cmd <= 1'b0;
        #1;
        check(rate_now, 8'h0A, "bad stored rate kept out");
    endtask

    // One whole frame after a quiet link, with an early stall to exercise the buffer.
    task automatic test_frame(input logic ascii, input int nbytes);
        logic [7:0] got;
        int         n;
        int         quiet;
        int         k;
        n     = 0;
        quiet = 0;
        k     = 0;
        got   = 8'h00;
        while (quiet < 40 && k < 5000) begin
            @(negedge clock);
            quiet = tx_valid ? 0 : quiet + 1;
            k++;
        end
        @(posedge clock);
        fmt_ascii <= ascii;
        while (n < nbytes && k < 5000) begin
            @(negedge clock);
            k++;
            if (tx_valid && tx_ready) begin
                got = tx_data;
                if (ascii && n % 9 == 3) begin
                    check(got, CHAR_COMMA, "comma place");
                end
                if (ascii && n % 9 == 7) begin
                    check(got, CHAR_SPACE, "space place");
                end
                if (ascii) begin
                    check(got == CHAR_CR, n == nbytes - 1, "CR only at end");
                end
                n++;
                if (n == 2) begin
                    @(posedge clock);
                    tx_ready <= 1'b0;
                    repeat (30) @(posedge clock);
                    tx_ready <= 1'b1;
                end
            end
        end
        check(got, CHAR_CR, "frame end");
        if (k >= 5000) begin
            failures++;
            $display("CHECK FAILED %0t frame timeout", $time);
            finish_test();
        end
    endtask

    // Spacing at a given rate: the gap in cycles follows from the rate table.
    task automatic test_gap(input logic [7:0] rate, input int gap);
        rate_cmd(rate);
        repeat (21000) @(posedge clock);
        send_byte(8'h2A, 1'b1);
        repeat (100) @(posedge clock);
        send_byte(8'h52, 1'b0);
        repeat (gap) @(posedge clock);
        send_byte(8'h0D, 1'b1);
    endtask

    // Bounded run: a hang counts as a failure.
    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        $display("CHECK FAILED %0t timeout", $time);
        finish_test();
    end

    initial begin
        {rst, rate_cmd_valid, defaults_cmd, restore_cmd, cmd_byte_valid} = 5'b10000;
        {store_cmd, zero_on, zero_off, fmt_ascii, baud_fast, adc_slow} = 6'b000000;
        tx_ready       = 1'b1;
        rate_cmd_value = 8'h00;
        nv_rate        = 8'h00;
        cmd_byte       = 8'h00;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1;
        check(rate_now, 8'h14, "rate after reset");
        check(tx_valid, 1'b0, "stream idle after reset");
        test_rates();
        test_settings();
        test_frame(1'b1, ASCII_BYTES);
        test_frame(1'b0, BIN_BYTES);
        adc_slow <= 1'b1;
        test_gap(8'h9A, 3000);
        test_gap(8'h14, 20000);
        finish_test();
    end
endmodule

bind msro_core msro_core_checker u_chk (
    .clock(clock), .rst(rst), .rate_cmd_valid(rate_cmd_valid),
    .rate_cmd_value(rate_cmd_value), .rate_cmd_reject(rate_cmd_reject),
    .defaults_cmd(defaults_cmd), .restore_cmd(restore_cmd), .nv_rate(nv_rate),
    .store_cmd(store_cmd), .nv_store(nv_store), .cmd_byte_valid(cmd_byte_valid),
    .cmd_byte(cmd_byte), .cmd_byte_accept(cmd_byte_accept), .cmd_byte_data(cmd_byte_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rate_now(rate_now));
